// file: verilog/wake_source_control_regs.sv
// wake source control register bank with serial access
//
// Summary of operation
// [R1] bit 7: second cyclic timer wake enable
// [R2] bit 6: first cyclic timer wake enable
// [R3] bit 2: watchdog stop-off high bit, hardware-settable
// [R4] companion low bit at watchdog bit 6
// [R5] reserved bits read only, always zero
// [R6] global policy: wakes only, or all status
// [R7] bit 5 selects measurement, drops inputs 1-2
// [R8] measurement in normal mode; ignore enables, levels
// [R9] bits 2..0 enable wake inputs 3..1
// [R10] host selects bus wakes via bus modes
// [R11] bus wake codes 01, 001, 101 selective
// [R12] fail-safe forces bus and external wake values
// [R13] external register reset 07, restart keeps fields
// [R14] internal register clears on reset
// [R15] restart keeps timer enables, clears rest
// [R16] three two-bit pull fields, reset zero
// [R17] pull codes none, down, up, automatic
// [R18] restart keeps pull fields, upper zero
// [R19] writes land only after complete frame
`timescale 1ns/100ps
`default_nettype none
module wake_source_control_regs
  import wake_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic chip_select_low_active_n,
  input wire logic restart_pulse,
  input wire logic failsafe_entry,
  input wire logic dog_hi_hw_set,
  input wire logic dog_hi_hw_val,
  input wire logic dog_stop_disable_lo,
  input wire logic normal_mode,
  input wire logic wake_event,
  input wire logic status_event,
  input wire logic level_one_in,
  input wire logic level_two_in,
  input wire logic [4:0] bus_mode_in,
  output logic miso,
  output logic miso_oe,
  output logic second_cycle_wake_on,
  output logic first_cycle_wake_on,
  output logic [1:0] dog_stop_cfg,
  output logic input_one_wake_on,
  output logic input_two_wake_on,
  output logic input_three_wake_on,
  output logic measure_enable,
  output logic level_one_out,
  output logic level_two_out,
  output logic int_req,
  output logic lin_wake_on,
  output logic can_wake_on,
  output logic can_selective_wake,
  output logic bus_force_stb,
  output logic [4:0] bus_force_low5,
  output pull_ctl_t input_one_pull_sel,
  output pull_ctl_t input_two_pull_sel,
  output pull_ctl_t input_three_pull_sel
);
  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic pull_ctl_t pull_decode(input logic [1:0] code);
    pull_ctl_t r;
    r = '0;
    case (code)
      PULL_NONE: r = '0;
      PULL_DOWN: r.down = 1'b1;
      PULL_UP: r.up = 1'b1;
      PULL_AUTO: r.auto_sw = 1'b1;
      default: r = '0;
    endcase
    return r; // [R17]
  endfunction

  logic [7:0] int_q, int_d, ext_q, ext_d, pull_q, pull_d, rd_data;
  logic [7:0] hdr;
  spi_word_t word;
  logic word_stb, wr_hit;

  spi_frame_rx u_rx (
    .ref_clk(ref_clk),
    .rst(rst),
    .sclk(sclk),
    .mosi(mosi),
    .chip_select_low_active_n(chip_select_low_active_n),
    .rd_data(rd_data),
    .hdr_q(hdr),
    .word_q(word),
    .word_stb_q(word_stb),
    .miso_q(miso),
    .miso_oe_q(miso_oe)
  );

  // ********************************************************************
  // register file
  // ********************************************************************
  // readback masks keep reserved positions at zero
  always_comb
  begin
    case (hdr[6:0])
      ADDR_INT_WAKE: rd_data = int_q & INT_WR_MASK; // [R5]
      ADDR_EXT_WAKE: rd_data = ext_q & EXT_WR_MASK;
      ADDR_PULL: rd_data = pull_q & PULL_WR_MASK;
      default: rd_data = ZERO_BYTE;
    endcase
  end

  // priority: fail-safe over restart over host write; hardware set last
  always_comb
  begin
    int_d = int_q;
    ext_d = ext_q;
    pull_d = pull_q;
    wr_hit = word_stb & word.write; // [R19]
    if (failsafe_entry)
      ext_d = (ext_q & EXT_KEEP_FAILSAFE) | EXT_SET_FAILSAFE; // [R12]
    else if (restart_pulse)
    begin
      int_d = int_q & INT_KEEP_RESTART; // [R15]
      ext_d = ext_q & EXT_KEEP_RESTART; // [R13]
      pull_d = pull_q & PULL_KEEP_RESTART; // [R18]
    end
    else if (wr_hit)
    begin
      case (word.addr)
        ADDR_INT_WAKE: int_d = word.data & INT_WR_MASK; // [R1] [R2] [R5]
        ADDR_EXT_WAKE: ext_d = word.data & EXT_WR_MASK; // [R5]
        ADDR_PULL: pull_d = word.data & PULL_WR_MASK; // [R16]
        default: int_d = int_q;
      endcase
    end
    // device-side update of the stop-mode bit wins over a host write
    if (dog_hi_hw_set)
      int_d[BIT_DOG_HI] = dog_hi_hw_val; // [R3]
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      int_q <= INT_WAKE_RST; // [R14]
      ext_q <= EXT_WAKE_RST; // [R13]
      pull_q <= PULL_RST; // [R16]
    end
    else
    begin
      int_q <= int_d;
      ext_q <= ext_d;
      pull_q <= pull_d;
    end
  end

  // ********************************************************************
  // decoded outputs
  // ********************************************************************
  logic meas;
  logic [2:0] can_mode;
  always_comb
  begin
    meas = ext_q[BIT_MEASURE];
    can_mode = bus_mode_in[2:0];
  end

  // every output is registered, so decodes lag the registers by a cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      second_cycle_wake_on <= 1'b0;
      first_cycle_wake_on <= 1'b0;
      dog_stop_cfg <= 2'h0;
      input_one_wake_on <= 1'b0;
      input_two_wake_on <= 1'b0;
      input_three_wake_on <= 1'b0;
      measure_enable <= 1'b0;
      level_one_out <= 1'b0;
      level_two_out <= 1'b0;
      int_req <= 1'b0;
      lin_wake_on <= 1'b0;
      can_wake_on <= 1'b0;
      can_selective_wake <= 1'b0;
      bus_force_stb <= 1'b0;
      bus_force_low5 <= 5'h00;
      input_one_pull_sel <= '0;
      input_two_pull_sel <= '0;
      input_three_pull_sel <= '0;
    end
    else
    begin
      second_cycle_wake_on <= int_q[BIT_SECOND_CYCLE]; // [R1]
      first_cycle_wake_on <= int_q[BIT_FIRST_CYCLE]; // [R2]
      dog_stop_cfg <= {int_q[BIT_DOG_HI], dog_stop_disable_lo}; // [R3] [R4]
      input_one_wake_on <= ext_q[BIT_IN_ONE] & ~meas; // [R7] [R9]
      input_two_wake_on <= ext_q[BIT_IN_TWO] & ~meas; // [R7] [R9]
      input_three_wake_on <= ext_q[BIT_IN_THREE]; // [R9]
      measure_enable <= meas & normal_mode; // [R8]
      level_one_out <= level_one_in & ~meas; // [R8]
      level_two_out <= level_two_in & ~meas; // [R8]
      int_req <= wake_event | (ext_q[BIT_GLOBAL_INT] & status_event); // [R6]
      // bus wakes come only from the host's mode choice [R10]
      lin_wake_on <= (bus_mode_in[4:3] == LIN_WAKE_MODE); // [R11]
      can_wake_on <= (can_mode == CAN_WAKE_MODE) | (can_mode == CAN_SEL_WAKE_MODE); // [R11]
      can_selective_wake <= (can_mode == CAN_SEL_WAKE_MODE); // [R11]
      bus_force_stb <= failsafe_entry; // [R12]
      bus_force_low5 <= BUS_FAILSAFE_LOW5; // [R12]
      input_one_pull_sel <= pull_decode(pull_q[PULL_ONE_LSB +: 2]); // [R16]
      input_two_pull_sel <= pull_decode(pull_q[PULL_TWO_LSB +: 2]);
      input_three_pull_sel <= pull_decode(pull_q[PULL_THREE_LSB +: 2]);
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_failsafe;
    failsafe_entry;
  endsequence
  sequence s_forced;
    (ext_q[2:0] == EXT_SET_FAILSAFE[2:0]) && bus_force_stb
      && (bus_force_low5 == BUS_FAILSAFE_LOW5);
  endsequence
  property p_failsafe;
    s_failsafe |=> s_forced;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("fail-safe values not forced"); // [R12]

  property p_reserved;
    ((int_q & ~INT_WR_MASK) == ZERO_BYTE) && ((ext_q & ~EXT_WR_MASK) == ZERO_BYTE)
      && ((pull_q & ~PULL_WR_MASK) == ZERO_BYTE);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [R5]

  property p_restart_int;
    restart_pulse && !failsafe_entry && !dog_hi_hw_set
      |=> int_q == ($past(int_q) & INT_KEEP_RESTART);
  endproperty
  a_restart_int: assert property (p_restart_int) else $error("internal restart wrong"); // [R15]

  property p_restart_ext;
    restart_pulse && !failsafe_entry |=> ext_q == ($past(ext_q) & EXT_KEEP_RESTART);
  endproperty
  a_restart_ext: assert property (p_restart_ext) else $error("external restart wrong"); // [R13]

  property p_restart_pull;
    restart_pulse && !failsafe_entry |=> pull_q[7:6] == 2'h0 && $stable(pull_q[5:0]);
  endproperty
  a_restart_pull: assert property (p_restart_pull) else $error("pull restart wrong"); // [R18]

  property p_meas_excl;
    meas && !failsafe_entry |=> !input_one_wake_on && !input_two_wake_on
      && !level_one_out && !level_two_out;
  endproperty
  a_meas_excl: assert property (p_meas_excl) else $error("measured input still wakes"); // [R7]

  property p_int_policy;
    !ext_q[BIT_GLOBAL_INT] && status_event && !wake_event |=> !int_req;
  endproperty
  a_int_policy: assert property (p_int_policy) else $error("status raised interrupt"); // [R6]

  property p_no_write;
    !word_stb && !restart_pulse && !failsafe_entry |=> $stable(pull_q) && $stable(ext_q);
  endproperty
  a_no_write: assert property (p_no_write) else $error("register changed without frame"); // [R19]

  property p_dog_hw;
    dog_hi_hw_set |=> int_q[BIT_DOG_HI] == $past(dog_hi_hw_val)
      ##1 dog_stop_cfg[1] == $past(dog_hi_hw_val, 2);
  endproperty
  a_dog_hw: assert property (p_dog_hw) else $error("stop-mode bit not updated"); // [R3]
endmodule
`default_nettype wire

// file: verilog/wake_regs_pkg.sv
// shared constants and types for the wake source register bank
package wake_regs_pkg;
  // ********************************************************************
  // serial frame layout
  // ********************************************************************
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned HDR_LAST_BIT = 7;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_CAP = 5'h11;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_LAST_IDX = 5'h0F;

  // ********************************************************************
  // register addresses, reset values and access masks
  // ********************************************************************
  localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
  localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
  localparam logic [6:0] ADDR_PULL = 7'h08;
  localparam logic [7:0] INT_WAKE_RST = 8'h00;
  localparam logic [7:0] EXT_WAKE_RST = 8'h07;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] INT_WR_MASK = 8'hC4;
  localparam logic [7:0] EXT_WR_MASK = 8'hA7;
  localparam logic [7:0] PULL_WR_MASK = 8'h3F;
  localparam logic [7:0] INT_KEEP_RESTART = 8'hC0;
  localparam logic [7:0] EXT_KEEP_RESTART = 8'hA7;
  localparam logic [7:0] PULL_KEEP_RESTART = 8'h3F;
  localparam logic [7:0] EXT_KEEP_FAILSAFE = 8'hA0;
  localparam logic [7:0] EXT_SET_FAILSAFE = 8'h07;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int unsigned BIT_SECOND_CYCLE = 7;
  localparam int unsigned BIT_FIRST_CYCLE = 6;
  localparam int unsigned BIT_DOG_HI = 2;
  localparam int unsigned BIT_DOG_LO = 6;
  localparam int unsigned BIT_GLOBAL_INT = 7;
  localparam int unsigned BIT_MEASURE = 5;
  localparam int unsigned BIT_IN_THREE = 2;
  localparam int unsigned BIT_IN_TWO = 1;
  localparam int unsigned BIT_IN_ONE = 0;
  localparam int unsigned PULL_ONE_LSB = 0;
  localparam int unsigned PULL_TWO_LSB = 2;
  localparam int unsigned PULL_THREE_LSB = 4;

  // ********************************************************************
  // pull and bus mode encodings
  // ********************************************************************
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] LIN_WAKE_MODE = 2'h1;
  localparam logic [2:0] CAN_WAKE_MODE = 3'h1;
  localparam logic [2:0] CAN_SEL_WAKE_MODE = 3'h5;
  localparam logic [4:0] BUS_FAILSAFE_LOW5 = 5'h09;

  typedef struct packed {
    logic write;
    logic [6:0] addr;
    logic [7:0] data;
  } spi_word_t;

  typedef struct packed {
    logic up;
    logic down;
    logic auto_sw;
  } pull_ctl_t;
endpackage

// file: verilog/spi_frame_rx.sv
// serial frame receiver: pin sync, 16-bit shift, readback shift-out
`timescale 1ns/100ps
`default_nettype none
module spi_frame_rx
  import wake_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic chip_select_low_active_n,
  input wire logic [7:0] rd_data,
  output logic [7:0] hdr_q,
  output spi_word_t word_q,
  output logic word_stb_q,
  output logic miso_q,
  output logic miso_oe_q
);
  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [2:0] sclk_s;
  logic [1:0] mosi_s;
  logic [2:0] cs_s;
  logic [4:0] cnt_q, cnt_d;
  logic [15:0] shift_q, shift_d;
  logic [7:0] hdr_d;
  spi_word_t word_d;
  logic word_stb_d, miso_d, miso_oe_d;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, cs_active;
  logic [4:0] bit_idx;

  // stage 0 is only read by stage 1; edges come from stages 1 and 2
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sclk_s <= 3'h0;
      mosi_s <= 2'h0;
      cs_s <= 3'h7;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk};
      mosi_s <= {mosi_s[0], mosi};
      cs_s <= {cs_s[1:0], chip_select_low_active_n};
    end
  end

  // ********************************************************************
  // frame shifter
  // ********************************************************************
  always_comb
  begin
    sclk_rise = sclk_s[1] & ~sclk_s[2];
    sclk_fall = ~sclk_s[1] & sclk_s[2];
    cs_rise = cs_s[1] & ~cs_s[2];
    cs_fall = ~cs_s[1] & cs_s[2];
    cs_active = ~cs_s[1];
    bit_idx = CNT_LAST_IDX - cnt_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    hdr_d = hdr_q;
    word_d = word_q;
    word_stb_d = 1'b0;
    miso_d = miso_q;
    miso_oe_d = miso_oe_q;
    if (cs_fall)
    begin
      cnt_d = 5'h00;
      miso_d = 1'b0;
      miso_oe_d = 1'b1;
    end
    else if (cs_active)
    begin
      if (sclk_rise)
      begin
        shift_d = {shift_q[14:0], mosi_s[1]};
        if (cnt_q != CNT_CAP)
          cnt_d = cnt_q + 5'h01; // saturates so long frames stay invalid
        if (cnt_q == 5'(HDR_LAST_BIT))
          hdr_d = {shift_q[6:0], mosi_s[1]};
      end
      // readback data appears in the second byte, header byte reads zero
      if (sclk_fall)
        miso_d = (cnt_q >= CNT_DATA_FIRST && cnt_q < CNT_FULL) ? rd_data[bit_idx[2:0]] : 1'b0;
    end
    else if (cs_rise)
    begin
      miso_oe_d = 1'b0;
      miso_d = 1'b0;
      if (cnt_q == CNT_FULL) // only a complete frame is handed on [R19]
      begin
        word_stb_d = 1'b1;
        word_d = shift_q;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      hdr_q <= 8'h00;
      word_q <= '0;
      word_stb_q <= 1'b0;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      hdr_q <= hdr_d;
      word_q <= word_d;
      word_stb_q <= word_stb_d;
      miso_q <= miso_d;
      miso_oe_q <= miso_oe_d;
    end
  end
endmodule
`default_nettype wire

// file: dv/spi_host_model.sv
// serial host model that frames register reads and writes for the bank
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
  import wake_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic miso,
  output logic sclk,
  output logic mosi,
  output logic chip_select_low_active_n
);
  // ********
  // idle levels
  // ********
  // clock stands still low between frames, select inactive
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    chip_select_low_active_n = 1'b1;
  end

  // advance n clocks, landing just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // one frame, msb first; fewer than sixteen bits gives an aborted frame
  // four clocks per phase leaves margin over the two-stage pin sync
  task automatic xfer(input spi_word_t w, input int nbits, output logic [7:0] rd);
    logic [15:0] f;
    f = w;
    rd = 8'h00;
    chip_select_low_active_n = 1'b0;
    step(4);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      mosi = f[i];
      step(4);
      if (i < 8)
        rd[i] = miso; // settled since the previous falling clock
      sclk = 1'b1;
      step(4);
      sclk = 1'b0;
    end
    step(4);
    chip_select_low_active_n = 1'b1; // frame only counts at this rise
    mosi = ~mosi; // released line must not keep the last bit
    step(8);
  endtask
endmodule
`default_nettype wire

// file: dv/wake_source_control_regs_test.sv
// self-checking bench for the wake source register bank
`timescale 1ns/100ps
`default_nettype none
module wake_source_control_regs_test;
  import wake_regs_pkg::*;
  logic ref_clk, rst, sclk, mosi, cs_n, restart_pulse, failsafe_entry;
  logic dog_hi_hw_set, dog_hi_hw_val, dog_stop_disable_lo, normal_mode;
  logic wake_event, status_event, level_one_in, level_two_in;
  logic [4:0] bus_mode_in, bus_force_low5;
  logic miso, miso_oe, second_cycle_wake_on, first_cycle_wake_on;
  logic [1:0] dog_stop_cfg;
  logic input_one_wake_on, input_two_wake_on, input_three_wake_on, measure_enable;
  logic level_one_out, level_two_out, int_req, lin_wake_on, can_wake_on;
  logic can_selective_wake, bus_force_stb;
  pull_ctl_t input_one_pull_sel, input_two_pull_sel, input_three_pull_sel;
  logic [7:0] v;
  int error_cnt = 0;
  int checks_done = 0;

  // ********
  // design and host
  // ********
  wake_source_control_regs dut (
    .ref_clk, .rst, .sclk, .mosi, .chip_select_low_active_n(cs_n), .restart_pulse,
    .failsafe_entry, .dog_hi_hw_set, .dog_hi_hw_val, .dog_stop_disable_lo,
    .normal_mode, .wake_event, .status_event, .level_one_in, .level_two_in,
    .bus_mode_in, .miso, .miso_oe, .second_cycle_wake_on, .first_cycle_wake_on,
    .dog_stop_cfg, .input_one_wake_on, .input_two_wake_on, .input_three_wake_on,
    .measure_enable, .level_one_out, .level_two_out, .int_req, .lin_wake_on,
    .can_wake_on, .can_selective_wake, .bus_force_stb, .bus_force_low5,
    .input_one_pull_sel, .input_two_pull_sel, .input_three_pull_sel
  );
  spi_host_model host (.ref_clk, .miso, .sclk, .mosi, .chip_select_low_active_n(cs_n));

  // free-running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ********
  // helpers
  // ********
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer('{1'b1, a, d}, FRAME_BITS, x);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    host.xfer('{1'b0, a, 8'h00}, FRAME_BITS, d);
  endtask

  // side levels go through one vector so each scenario names every input
  task automatic levels(input logic [3:0] l);
    {dog_stop_disable_lo, normal_mode, level_one_in, level_two_in} = l;
  endtask

  // {restart, fail-safe, stop-bit set, stop-bit value}; pulses last one edge
  task automatic strobe(input logic [3:0] p);
    {restart_pulse, failsafe_entry, dog_hi_hw_set, dog_hi_hw_val} = p;
    if (p != 4'h0)
    begin
      host.step(1);
      {restart_pulse, failsafe_entry, dog_hi_hw_set} = 3'h0;
    end
  endtask

  // pull decode worked out from the field codes
  function automatic pull_ctl_t dec(input logic [1:0] c);
    dec = '{up: c == 2'h2, down: c == 2'h1, auto_sw: c == 2'h3};
  endfunction

  // one-cycle event, then count cycles with the interrupt request high
  task automatic ev(input logic w, input logic s, input logic [15:0] exp);
    int n;
    n = 0;
    wake_event = w;
    status_event = s;
    host.step(1);
    wake_event = 1'b0;
    status_event = 1'b0;
    repeat (4)
    begin
      if (int_req === 1'b1)
        n++;
      host.step(1);
    end
    chk(16'(n), exp, "int_req cycles");
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset_values();
    rd(ADDR_INT_WAKE, v); chk(v, 8'h00, "int reset");
    rd(ADDR_EXT_WAKE, v); chk(v, 8'h07, "ext reset");
    rd(ADDR_PULL, v); chk(v, 8'h00, "pull reset");
    chk({input_three_wake_on, input_two_wake_on, input_one_wake_on}, 3'h7, "wk en");
  endtask

  // reserved bits ignore writes; hardware may set the stop bit itself
  task automatic t_internal();
    levels(4'h8);
    wr(ADDR_INT_WAKE, 8'hFF);
    rd(ADDR_INT_WAKE, v); chk(v, 8'hC4, "int all ones");
    chk({second_cycle_wake_on, first_cycle_wake_on, dog_stop_cfg}, 4'hF, "int out");
    wr(ADDR_INT_WAKE, 8'h40);
    chk({second_cycle_wake_on, first_cycle_wake_on, dog_stop_cfg}, 4'h5, "timer1");
    levels(4'h0);
    strobe(4'h3);
    host.step(3);
    chk(dog_stop_cfg, 2'h2, "dog cfg");
    rd(ADDR_INT_WAKE, v); chk(v, 8'h44, "hw set bit");
    strobe(4'h2);
    host.step(3);
    chk(dog_stop_cfg, 2'h0, "dog cfg clear");
    rd(ADDR_INT_WAKE, v);
    chk(v, 8'h40, "hw clear bit");
  endtask

  // measurement select drops inputs one and two and masks their levels
  task automatic t_external();
    levels(4'h7);
    wr(ADDR_EXT_WAKE, 8'hFF);
    rd(ADDR_EXT_WAKE, v); chk(v, 8'hA7, "ext all ones");
    chk({measure_enable, level_one_out, level_two_out, input_three_wake_on,
      input_two_wake_on, input_one_wake_on}, 6'h24, "measure");
    levels(4'h3);
    host.step(3);
    chk(measure_enable, 1'b0, "measure off in stop");
    wr(ADDR_EXT_WAKE, 8'h05);
    chk({measure_enable, level_one_out, level_two_out, input_three_wake_on,
      input_two_wake_on, input_one_wake_on}, 6'h1D, "wake 3 and 1");
    levels(4'h2);
    host.step(3);
    chk({level_one_out, level_two_out}, 2'h2, "levels pass");
    wr(ADDR_EXT_WAKE, 8'h02);
    chk({input_three_wake_on, input_two_wake_on, input_one_wake_on}, 3'h2, "wake 2");
  endtask

  task automatic t_interrupt();
    ev(1'b0, 1'b1, 16'd0);
    ev(1'b1, 1'b0, 16'd1);
    wr(ADDR_EXT_WAKE, 8'h80);
    ev(1'b0, 1'b1, 16'd1);
  endtask

  // distinct code per field so a swapped field shows up
  task automatic t_pull();
    logic [1:0] c;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(ADDR_PULL, {2'h3, c, c + 2'h1, c + 2'h2});
      rd(ADDR_PULL, v); chk(v, {2'h0, c, c + 2'h1, c + 2'h2}, "pull rd");
      chk({input_three_pull_sel, input_two_pull_sel, input_one_pull_sel},
        {dec(c), dec(c + 2'h1), dec(c + 2'h2)}, "pull decode");
    end
  endtask

  // aborted frame, read frame and unmapped address leave the bank alone
  task automatic t_frames();
    wr(ADDR_PULL, 8'h15);
    host.xfer('{1'b1, ADDR_PULL, 8'h2A}, 12, v);
    host.xfer('{1'b0, ADDR_PULL, 8'h2A}, FRAME_BITS, v);
    wr(7'h09, 8'hFF);
    rd(7'h09, v); chk(v, 8'h00, "unmapped");
    rd(ADDR_PULL, v); chk(v, 8'h15, "abort kept");
  endtask

  task automatic t_restart();
    wr(ADDR_INT_WAKE, 8'hFF);
    wr(ADDR_EXT_WAKE, 8'hFF);
    wr(ADDR_PULL, 8'hFF);
    strobe(4'h8);
    host.step(3);
    rd(ADDR_INT_WAKE, v); chk(v, 8'hC0, "int restart");
    rd(ADDR_EXT_WAKE, v); chk(v, 8'hA7, "ext restart");
    rd(ADDR_PULL, v); chk(v, 8'h3F, "pull restart");
  endtask

  // fail-safe keeps policy and measure bits, forces the three wake inputs on
  task automatic t_failsafe(input logic [7:0] pre, input logic [7:0] post);
    int n;
    n = 0;
    wr(ADDR_EXT_WAKE, pre);
    strobe(4'h4);
    repeat (4)
    begin
      if (bus_force_stb === 1'b1)
        n++;
      host.step(1);
    end
    chk(16'(n), 16'd1, "bus force pulse");
    chk(bus_force_low5, 5'h09, "bus force value");
    rd(ADDR_EXT_WAKE, v); chk(v, post, "ext failsafe");
  endtask

  // every bus mode code against the wake-capable decodes
  task automatic t_bus();
    for (int i = 0; i < 32; i++)
    begin
      bus_mode_in = 5'(i); // host sets bus wakes through the mode fields
      host.step(3);
      chk({lin_wake_on, can_wake_on, can_selective_wake},
        {bus_mode_in[4:3] == 2'h1, bus_mode_in[1:0] == 2'h1,
        bus_mode_in[2:0] == 3'h5}, "bus decode");
    end
  endtask

  // soft reset in mid-run brings every register back to its reset value
  task automatic t_soft_reset();
    wr(ADDR_EXT_WAKE, 8'hA0);
    rst = 1'b1;
    host.step(2);
    rst = 1'b0;
    host.step(2);
    rd(ADDR_INT_WAKE, v);
    chk(v, 8'h00, "int soft reset");
    rd(ADDR_EXT_WAKE, v);
    chk(v, 8'h07, "ext soft reset");
    rd(ADDR_PULL, v);
    chk(v, 8'h00, "pull soft reset");
  endtask

  // ********
  // run control
  // ********
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // about 40 frames of 150 clocks fit well inside this span
  initial
  begin
    #300000;
    error_cnt++;
    final_report();
  end

  initial
  begin
    rst = 1'b1;
    strobe(4'h0);
    levels(4'h0);
    wake_event = 1'b0;
    status_event = 1'b0;
    bus_mode_in = 5'h00;
    host.step(4);
    rst = 1'b0;
    host.step(2);
    t_reset_values();
    t_internal();
    t_external();
    t_interrupt();
    t_pull();
    t_frames();
    t_restart();
    t_failsafe(8'hA0, 8'hA7);
    t_failsafe(8'h00, 8'h07);
    t_bus();
    t_soft_reset();
    final_report();
  end
endmodule
`default_nettype wire
